//--- design/tap_consts.vh
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
// Instruction register
`define IR_LEN 10
`define IR_RESET_VAL 10'h3FF
`define IR_CAPTURE_VAL 10'h001
`define OP_SAMPLE 10'h005
`define OP_EXTEST 10'h00F
`define OP_BYPASS 10'h3FF
`define OP_USERCODE 10'h007
`define OP_IDCODE 10'h006
`define OP_HIGHZ 10'h00B
`define OP_CLAMP 10'h00A
`define OP_USER_CHAIN_0_INSTR 10'h00C
`define OP_USER_CHAIN_1_INSTR 10'h00E
// Configuration instruction range (upper code block)
`define OP_ISC_MASK 10'h300
`define OP_ISC_VAL 10'h200
// Data registers
`define DR_LEN 32
`define USERCODE_RESET 32'hFFFFFFFF
`define ID_VERSION_MSB 31
`define ID_VERSION_LSB 28
// Boundary register lengths per density
`define BSR_LEN_A 240
`define BSR_LEN_B 480
`define BSR_LEN_C 636
`define BSR_LEN_D 816
// TAP states (one-hot)
`define ST_W 16
`endif

//--- design/sync2.v
/*
 Two-flop synchroniser for one bit.
 Assumes the input is asynchronous to clk_i; output is the second flop.
*/
`timescale 1ns/100ps
module sync2
(
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Data
	input wire d_i,
	output reg q_o
);
	reg stage;
	always @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			stage <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			stage <= d_i;
			q_o <= stage;
		end
	end
endmodule // sync2

//--- design/jtag_boundary_scan_tap.v
/*
 Test access port: TAP state machine, 10-bit instruction register, decoder,
 bypass, identification, user code, boundary register and pin control.
 Assumes tck/tms/tdi/trst_n come from an external tester, slow against sys_clk_i;
 all are synchronised and tck edges are detected on the system clock.
*/
`timescale 1ns/100ps
`include "tap_consts.vh"
module jtag_boundary_scan_tap
#(
	parameter BSR_LEN = `BSR_LEN_A,
	parameter [3:0] ID_VERSION = 4'h0,
	// Arbitrary neutral part and maker fields
	parameter [26:0] ID_PART_MAKER = 27'h0123456,
	parameter [31:0] USERCODE = `USERCODE_RESET,
	parameter NPIN = BSR_LEN / 3
)
(
	// System
	input wire sys_clk_i,
	input wire resetn_i,
	// Test port pins
	input wire tck_i,
	input wire tms_i,
	input wire tdi_i,
	input wire trst_n_i,
	output reg tdo_o,
	output reg tdo_oe_n_o,
	// Core-side I/O: core wants to drive core_out_i/core_oe_i; pin_in_i is read from the pads
	input wire [NPIN-1:0] core_out_i,
	input wire [NPIN-1:0] core_oe_i,
	input wire [NPIN-1:0] pin_in_i,
	// Pad control
	output reg [NPIN-1:0] pad_out_o,
	output reg [NPIN-1:0] pad_oe_n_o,
	output reg pad_keep_pull_o,
	// User chain interface
	input wire user_tdo0_i,
	input wire user_tdo1_i,
	output reg user_sel0_o,
	output reg user_sel1_o,
	output reg user_tdi_o,
	output reg [15:0] user_state_o,
	output reg user_tck_rise_o,
	output reg user_tms_o,
	// Configuration engine interface
	output reg isc_sel_o,
	output reg [9:0] isc_op_o,
	input wire isc_tdo_i
);
	localparam S_RESET = 16'h0001, S_IDLE = 16'h0002, S_SDR = 16'h0004, S_CDR = 16'h0008;
	localparam S_SHDR = 16'h0010, S_E1DR = 16'h0020, S_PDR = 16'h0040, S_E2DR = 16'h0080;
	localparam S_UDR = 16'h0100, S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHIR = 16'h0800;
	localparam S_E1IR = 16'h1000, S_PIR = 16'h2000, S_E2IR = 16'h4000, S_UIR = 16'h8000;

	wire tck_s, tms_s, tdi_s, trst_s;
	reg tck_d;
	reg [15:0] state, next_state;
	reg [9:0] ir_sh, ir;
	reg byp;
	reg [31:0] dr32;
	reg [BSR_LEN-1:0] bsr_sh, bsr_up;
	wire rise = tck_s & ~tck_d;
	wire fall = ~tck_s & tck_d;
	wire trst_n = trst_s;

	sync2 u_sync_tck (.clk_i(sys_clk_i), .resetn_i(resetn_i), .d_i(tck_i), .q_o(tck_s));
	sync2 u_sync_tms (.clk_i(sys_clk_i), .resetn_i(resetn_i), .d_i(tms_i), .q_o(tms_s));
	sync2 u_sync_tdi (.clk_i(sys_clk_i), .resetn_i(resetn_i), .d_i(tdi_i), .q_o(tdi_s));
	sync2 u_sync_trst (.clk_i(sys_clk_i), .resetn_i(resetn_i), .d_i(trst_n_i), .q_o(trst_s));

	// Pad inputs come from the board; capture sees them two clocks late
	wire [NPIN-1:0] pin_s;
	genvar p;
	generate
		for (p = 0; p < NPIN; p = p + 1)
		begin : g_pin_sync
			sync2 u_sync_pin (.clk_i(sys_clk_i), .resetn_i(resetn_i), .d_i(pin_in_i[p]),
				.q_o(pin_s[p]));
		end
	endgenerate

	// Decode
	wire is_sample = (ir == `OP_SAMPLE);
	wire is_extest = (ir == `OP_EXTEST);
	wire is_idcode = (ir == `OP_IDCODE);
	wire is_ucode = (ir == `OP_USERCODE);
	wire is_highz = (ir == `OP_HIGHZ);
	wire is_clamp = (ir == `OP_CLAMP);
	wire is_user_chain_0_instr = (ir == `OP_USER_CHAIN_0_INSTR);
	wire is_user_chain_1_instr = (ir == `OP_USER_CHAIN_1_INSTR);
	wire is_isc = ((ir & `OP_ISC_MASK) == `OP_ISC_VAL);
	wire sel_bsr = is_sample | is_extest;
	wire sel_dr32 = is_idcode | is_ucode;
	wire is_user = is_user_chain_0_instr | is_user_chain_1_instr;
	wire sel_byp = ~(sel_bsr | sel_dr32 | is_user | is_isc);
	wire [31:0] id_val = {ID_VERSION, ID_PART_MAKER, 1'b1};

	always @*
	begin
		next_state = state;
		case (state)
			S_RESET: next_state = tms_s ? S_RESET : S_IDLE;
			S_IDLE: next_state = tms_s ? S_SDR : S_IDLE;
			S_SDR: next_state = tms_s ? S_SIR : S_CDR;
			S_CDR: next_state = tms_s ? S_E1DR : S_SHDR;
			S_SHDR: next_state = tms_s ? S_E1DR : S_SHDR;
			S_E1DR: next_state = tms_s ? S_UDR : S_PDR;
			S_PDR: next_state = tms_s ? S_E2DR : S_PDR;
			S_E2DR: next_state = tms_s ? S_UDR : S_SHDR;
			S_UDR: next_state = tms_s ? S_SDR : S_IDLE;
			S_SIR: next_state = tms_s ? S_RESET : S_CIR;
			S_CIR: next_state = tms_s ? S_E1IR : S_SHIR;
			S_SHIR: next_state = tms_s ? S_E1IR : S_SHIR;
			S_E1IR: next_state = tms_s ? S_UIR : S_PIR;
			S_PIR: next_state = tms_s ? S_E2IR : S_PIR;
			S_E2IR: next_state = tms_s ? S_UIR : S_SHIR;
			S_UIR: next_state = tms_s ? S_SDR : S_IDLE;
			default: next_state = S_RESET;
		endcase
	end

	// Boundary capture: pins' input, output and enable per cell triplet
	wire [BSR_LEN-1:0] bsr_cap;
	genvar g;
	generate
		for (g = 0; g < BSR_LEN; g = g + 1)
		begin : g_cap
			if (g / 3 < NPIN)
			begin : g_in
				assign bsr_cap[g] = (g % 3 == 0) ? pin_s[g/3] :
					(g % 3 == 1) ? core_out_i[g/3] : core_oe_i[g/3];
			end
			else
			begin : g_pad
				assign bsr_cap[g] = 1'b0;
			end
		end
	endgenerate

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tck_d <= 1'b0;
			state <= S_RESET;
			ir_sh <= `IR_RESET_VAL;
			ir <= `IR_RESET_VAL;
			byp <= 1'b0;
			dr32 <= 32'h00000000;
			bsr_sh <= {BSR_LEN{1'b0}};
			bsr_up <= {BSR_LEN{1'b0}};
		end
		else if (!trst_n)
		begin
			tck_d <= tck_s;
			state <= S_RESET;
			ir <= `IR_RESET_VAL;
			ir_sh <= `IR_RESET_VAL;
		end
		else
		begin
			tck_d <= tck_s;
			if (rise)
			begin
				state <= next_state;
				if (state == S_RESET)
				begin
					// Reset selects bypass so pins stay in normal use
					ir <= `IR_RESET_VAL;
				end
				if (state == S_CIR)
					ir_sh <= `IR_CAPTURE_VAL;
				if (state == S_SHIR)
					ir_sh <= {tdi_s, ir_sh[9:1]};
				if (state == S_UIR)
					ir <= ir_sh;
				if (state == S_CDR)
				begin
					byp <= 1'b0;
					dr32 <= is_idcode ? id_val : USERCODE;
					if (sel_bsr)
						bsr_sh <= bsr_cap;
				end
				if (state == S_SHDR)
				begin
					// bypass bit shifts only while it is the selected path
					if (sel_byp)
						byp <= tdi_s;
					if (sel_dr32)
						dr32 <= {tdi_s, dr32[31:1]};
					if (sel_bsr)
						bsr_sh <= {tdi_s, bsr_sh[BSR_LEN-1:1]};
				end
				if (state == S_UDR && sel_bsr)
					bsr_up <= bsr_sh;
			end
		end
	end

	integer i;
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tdo_o <= 1'b0;
			tdo_oe_n_o <= 1'b1;
			pad_out_o <= {NPIN{1'b0}};
			pad_oe_n_o <= {NPIN{1'b1}};
			pad_keep_pull_o <= 1'b1;
			user_sel0_o <= 1'b0;
			user_sel1_o <= 1'b0;
			user_tdi_o <= 1'b0;
			user_state_o <= 16'h0001;
			user_tck_rise_o <= 1'b0;
			user_tms_o <= 1'b0;
			isc_sel_o <= 1'b0;
			isc_op_o <= 10'h000;
		end
		else
		begin
			// TDO changes on the falling TCK edge
			// Gives the tester half a TCK period of settled data
			if (fall)
			begin
				tdo_oe_n_o <= ~(state == S_SHIR || state == S_SHDR);
				if (state == S_SHIR)
					tdo_o <= ir_sh[0];
				else if (sel_bsr)
					tdo_o <= bsr_sh[0];
				else if (sel_dr32)
					tdo_o <= dr32[0];
				else if (is_user_chain_0_instr)
					tdo_o <= user_tdo0_i;
				else if (is_user_chain_1_instr)
					tdo_o <= user_tdo1_i;
				else if (is_isc)
					tdo_o <= isc_tdo_i;
				// unknown codes end here on the bypass bit
				else
					tdo_o <= byp;
			end
			// TAP state and signals exposed for user chains
			user_sel0_o <= is_user_chain_0_instr;
			user_sel1_o <= is_user_chain_1_instr;
			user_tdi_o <= is_user ? tdi_s : 1'b0;
			user_state_o <= is_user ? state : 16'h0000;
			user_tck_rise_o <= is_user & rise;
			user_tms_o <= is_user ? tms_s : 1'b0;
			isc_sel_o <= is_isc;
			isc_op_o <= is_isc ? ir : 10'h000;
			// pulls and bus-hold never disabled here
			pad_keep_pull_o <= 1'b1;
			for (i = 0; i < NPIN; i = i + 1)
			begin
				if (is_highz)
				begin
					pad_out_o[i] <= 1'b0;
					pad_oe_n_o[i] <= 1'b1;
				end
				else if (is_extest | is_clamp)
				begin
					pad_out_o[i] <= bsr_up[3*i+1];
					pad_oe_n_o[i] <= ~bsr_up[3*i+2];
				end
				else
				begin
					pad_out_o[i] <= core_out_i[i];
					pad_oe_n_o[i] <= ~core_oe_i[i];
				end
			end
		end
	end
endmodule // jtag_boundary_scan_tap

//--- test/jtag_host.sv
/*
 Tester model: walks the TAP and shifts IR or DR frames, LSB first.
 Assumes the bench waits until the device is out of reset before calling.
*/
`timescale 1ns/100ps
module jtag_host
(
	// Test port
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end
	// Long low phase: TDO lands several system clocks after the fall
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#500 q = tdo_i;
		tck_o = 1'b1;
		#300 tck_o = 1'b0;
	endtask
	task automatic idle();
		logic b;
		repeat (5) step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask
	task automatic scan(input logic ir, input int n, input logic [255:0] d, output logic [255:0] q);
		logic b;
		q = '0;
		step(1'b1, 1'b0, b);
		if (ir)
			step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
		step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, d[i], b);
			q[i] = b;
		end
		step(1'b1, 1'b0, b);
		step(1'b0, 1'b0, b);
	endtask
endmodule // jtag_host

//--- test/jtag_boundary_scan_tap_properties.sv
/*
 Checker on the test port's top-level outputs.
 Assumes TCK stays low at least five system clocks per low phase.
*/
`timescale 1ns/100ps
module jtag_boundary_scan_tap_properties
#(
	parameter NPIN = 80
)
(
	// System
	input wire sys_clk_i,
	input wire resetn_i,
	// Watched
	input wire tck_i,
	input wire tms_i,
	input wire tdi_i,
	input wire tdo_o,
	input wire [NPIN-1:0] pad_oe_n_o,
	input wire pad_keep_pull_o,
	input wire user_sel0_o,
	input wire user_sel1_o,
	input wire user_tdi_o,
	input wire [15:0] user_state_o,
	input wire user_tck_rise_o,
	input wire user_tms_o,
	input wire isc_sel_o,
	input wire [9:0] isc_op_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wire usr = user_sel0_o | user_sel1_o;
	a_one_chain: assert property (!(user_sel0_o && user_sel1_o) && !(usr && isc_sel_o))
		else $error("two scan paths selected");
	a_state_hidden: assert property ($past(resetn_i) && !usr && !$past(usr) |-> user_state_o == 16'h0)
		else $error("state shown without user instruction");
	a_state_onehot: assert property (usr |-> $onehot(user_state_o))
		else $error("user state not one-hot");
	a_user_gate: assert property (!usr && !$past(usr) |-> !user_tdi_o && !user_tms_o)
		else $error("user signals leak");
	a_user_follow: assert property (usr |-> user_tdi_o == $past(tdi_i, 3) &&
		user_tms_o == $past(tms_i, 3))
		else $error("user tdi or tms not forwarded");
	a_pull_kept: assert property ($past(resetn_i) |-> pad_keep_pull_o)
		else $error("pull-ups dropped");
	a_isc_code: assert property (isc_sel_o |-> isc_op_o[9:8] == 2'b10)
		else $error("bad configuration code");
	a_isc_steady: assert property (isc_sel_o && $past(isc_sel_o) |-> $stable(isc_op_o))
		else $error("configuration code moved");
	a_tck_pulse: assert property (user_tck_rise_o |-> usr && $past(tck_i, 2) ##1 !user_tck_rise_o)
		else $error("bad tck rise pulse");
	a_tdo_fall: assert property ($changed(tdo_o) |-> !$past(tck_i))
		else $error("tdo moved while tck high");
	cover property (user_sel0_o);
	cover property (user_sel1_o);
	cover property (isc_sel_o);
	cover property (&pad_oe_n_o);
endmodule // jtag_boundary_scan_tap_properties
bind jtag_boundary_scan_tap jtag_boundary_scan_tap_properties #(.NPIN(NPIN))
	i_jtag_boundary_scan_tap_properties (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
	.tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .pad_oe_n_o(pad_oe_n_o),
	.pad_keep_pull_o(pad_keep_pull_o), .user_sel0_o(user_sel0_o), .user_sel1_o(user_sel1_o),
	.user_tdi_o(user_tdi_o), .user_state_o(user_state_o), .user_tck_rise_o(user_tck_rise_o),
	.user_tms_o(user_tms_o), .isc_sel_o(isc_sel_o), .isc_op_o(isc_op_o));

//--- test/jtag_boundary_scan_tap_test.sv
/*
 Bench: instruction table loop, then preload, clamp, extest and reset.
 Assumes the default 240-cell boundary register.
*/
`timescale 1ns/100ps
`include "tap_consts.vh"
module jtag_boundary_scan_tap_test;
	localparam NPIN = `BSR_LEN_A / 3;
	localparam logic [3:0] VER = 4'hA;
	// Arbitrary identity field
	localparam logic [26:0] PM = 27'h0123456;
	localparam logic [31:0] D = 32'hC3A50F96;
	localparam logic [31:0] BYP = {D[30:0], 1'b0};
	typedef struct packed {logic [9:0] c; logic [31:0] d; logic [1:0] m; logic [2:0] sel;} row_t;
	row_t rows[8] = '{'{`OP_BYPASS, BYP, 2'h0, 3'h0}, '{`OP_IDCODE, {VER, PM, 1'b1}, 2'h0, 3'h0},
		'{`OP_USERCODE, 32'hFFFFFFFF, 2'h0, 3'h0}, '{`OP_HIGHZ, BYP, 2'h1, 3'h0},
		'{`OP_USER_CHAIN_0_INSTR, 32'hFFFFFFFF, 2'h0, 3'h1},
		'{`OP_USER_CHAIN_1_INSTR, 32'h0, 2'h0, 3'h2},
		'{10'h123, BYP, 2'h0, 3'h0}, '{10'h2A5, 32'hFFFFFFFF, 2'h2, 3'h4}};
	logic sys_clk_i = 1'b0, resetn_i = 1'b0, trst_n_i = 1'b1, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o;
	logic [NPIN-1:0] core_out_i = {20{4'h9}}, core_oe_i = {10{8'hC3}}, pin_in_i = {20{4'h6}};
	logic [NPIN-1:0] pad_out_o, pad_oe_n_o, pex, poen;
	logic pad_keep_pull_o, user_tdo0_i = 1'b1, user_tdo1_i = 1'b0, isc_tdo_i = 1'b1;
	logic user_sel0_o, user_sel1_o, user_tdi_o, user_tck_rise_o, user_tms_o, isc_sel_o;
	logic [15:0] user_state_o;
	logic [9:0] isc_op_o;
	logic [255:0] q, pre = {8{32'h5A3C96E1}};
	int n_mismatch = 0, total_checks = 0;
	jtag_boundary_scan_tap #(.ID_VERSION(VER), .ID_PART_MAKER(PM)) i_jtag_boundary_scan_tap (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
		.trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .core_out_i(core_out_i),
		.core_oe_i(core_oe_i), .pin_in_i(pin_in_i), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
		.pad_keep_pull_o(pad_keep_pull_o), .user_tdo0_i(user_tdo0_i), .user_tdo1_i(user_tdo1_i),
		.user_sel0_o(user_sel0_o), .user_sel1_o(user_sel1_o), .user_tdi_o(user_tdi_o),
		.user_state_o(user_state_o), .user_tck_rise_o(user_tck_rise_o), .user_tms_o(user_tms_o),
		.isc_sel_o(isc_sel_o), .isc_op_o(isc_op_o), .isc_tdo_i(isc_tdo_i));
	jtag_host i_jtag_host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
	always #50 sys_clk_i = ~sys_clk_i;
	task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic load(input logic [9:0] c);
		i_jtag_host.scan(1'b1, 10, {246'h0, c}, q);
		check("ir capture", 256'h1, q);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	function automatic logic [NPIN-1:0] caps(input logic [255:0] v);
		for (int k = 0; k < NPIN; k++)
			caps[k] = v[3 * k];
	endfunction
	initial
	begin
		settle(20);
		resetn_i = 1'b1;
		// tester holds off until the device is up
		settle(5);
		i_jtag_host.idle();
		foreach (rows[i])
		begin
			core_out_i = ~core_out_i;
			load(rows[i].c);
			i_jtag_host.scan(1'b0, 32, {224'h0, D}, q);
			check("dr out", rows[i].d, q);
			settle(3);
			check("select", rows[i].sel, {isc_sel_o, user_sel1_o, user_sel0_o});
			check("isc op", rows[i].sel[2] ? rows[i].c : 10'h0, isc_op_o);
			check("tdo released", 1'b1, tdo_oe_n_o);
			check("state", rows[i].sel[1:0] != 0 ? 16'h2 : 16'h0, user_state_o);
			if (rows[i].m == 2'h1)
				check("pads hz", {NPIN{1'b1}}, pad_oe_n_o);
			else if (rows[i].m == 2'h0)
				check("pads", {core_out_i, ~core_oe_i}, {pad_out_o, pad_oe_n_o});
			$display("row %0d done", i);
		end
		load(`OP_SAMPLE);
		i_jtag_host.scan(1'b0, 256, pre, q);
		check("sample capture", pin_in_i, caps(q));
		check("bsr length", pre[15:0], q[255:240]);
		for (int k = 0; k < NPIN; k++)
		begin
			pex[k] = pre[3 * k + 17];
			poen[k] = ~pre[3 * k + 18];
		end
		load(`OP_CLAMP);
		i_jtag_host.scan(1'b0, 32, {224'h0, D}, q);
		check("clamp dr", BYP, q);
		check("clamp pads", {pex, poen}, {pad_out_o, pad_oe_n_o});
		load(`OP_EXTEST);
		pin_in_i = ~pin_in_i;
		settle(3);
		check("extest pads", {pex, poen}, {pad_out_o, pad_oe_n_o});
		i_jtag_host.scan(1'b0, 256, pre, q);
		check("extest capture", pin_in_i, caps(q));
		$display("boundary tests done");
		trst_n_i = 1'b0;
		settle(4);
		trst_n_i = 1'b1;
		settle(3);
		check("after test reset", {core_out_i, ~core_oe_i}, {pad_out_o, pad_oe_n_o});
		$display("test reset done");
		resetn_i = 1'b0;
		settle(2);
		check("in reset", {{NPIN{1'b1}}, 17'h3}, {pad_oe_n_o, user_state_o, tdo_oe_n_o});
		resetn_i = 1'b1;
		settle(3);
		check("after reset", {core_out_i, ~core_oe_i}, {pad_out_o, pad_oe_n_o});
		$display("reset test done");
		print_verdict();
	end
	initial
	begin
		repeat (60000) @(posedge sys_clk_i);
		n_mismatch++;
		print_verdict();
	end
endmodule // jtag_boundary_scan_tap_test
